//--- inc/cpfs_pkg.sv
package cpfs_pkg;
	// ------------------------------------------------------------
	// register map (word indices; byte address is index times four)
	// ------------------------------------------------------------
	localparam logic [15:0] CPFS_IDX_POLARITY = 16'h30E4;
	localparam logic [15:0] CPFS_IDX_STATUS = 16'h30E5;
	localparam logic [15:0] CPFS_IDX_CTL = 16'h30E6;
	localparam logic [7:0] CPFS_POLARITY_RST = 8'h00;
	localparam logic [7:0] CPFS_FIN_EN_RST = 8'h00;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CPFS_STAT_AGG = 7;
	localparam int CPFS_STAT_WPROT = 6;
	localparam int CPFS_STAT_FLTIN = 5;
	localparam int CPFS_CTL_WPOFF = 0;
	localparam int CPFS_CTL_FLTEN = 1;
	localparam int CPFS_CTL_FIN_LSB = 4;
	localparam int CPFS_NUM_FIN = 4;
	localparam logic [1:0] CPFS_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] CPFS_HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic sel;
		logic write;
		logic [15:0] idx;
	} cpfs_aphase_t;
endpackage

//--- core/cpfs_top.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - each of eight polarity bits: 0 active high, 1 active low
// - polarity writes take effect only while write protect is disabled
// - with fault control on and a fault on an enabled input, channel drives its polarity value
// - fault status bit 7 is the OR of all per-input fault flags
// - flag cleared by read while set, then write 0, with no fault present
// - writing 1 to the aggregate fault flag does nothing
// - new fault between the read and the write abandons the clear
// - clearing the per-input flags one by one clears the aggregate flag
// - enable is inverse of disable; 1 sets it, read then disable clears it
// - per-input flag sets only with fault control, input enabled, fault seen
module cpfs_top
	import cpfs_pkg::*;
#(
	parameter int NCH = 8
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// channel waveforms and faults
	input wire logic [NCH-1:0] ch_wave,
	input wire logic [cpfs_pkg::CPFS_NUM_FIN-1:0] fault_in,
	// channel pins
	output logic [NCH-1:0] ch_out
);
	import cpfs_pkg::*;

	// ------------------------------------------------------------
	// bus address phase capture
	// ------------------------------------------------------------
	cpfs_aphase_t ap_q;
	logic [NCH-1:0] polarity_q;
	logic wp_off_q;
	logic flten_q;
	logic [CPFS_NUM_FIN-1:0] fin_en_q;
	logic [CPFS_NUM_FIN-1:0] ff_q;
	logic [CPFS_NUM_FIN-1:0] armed_q;
	logic wp_armed_q;
	logic [CPFS_NUM_FIN-1:0] det;
	logic agg_flag;
	logic fault_any;
	logic wr_polar, wr_stat, wr_ctl, rd_stat;
	logic [7:0] wb;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ap_q <= '0;
		else if (hready)
		begin
			ap_q.sel <= hsel && htrans == CPFS_HTRANS_NONSEQ
				&& hsize == CPFS_HSIZE_WORD;
			ap_q.write <= hwrite;
			ap_q.idx <= haddr[17:2];
		end
	end

	assign wb = hwdata[7:0];
	assign wr_polar = ap_q.sel && ap_q.write
		&& ap_q.idx == CPFS_IDX_POLARITY;
	assign wr_stat = ap_q.sel && ap_q.write
		&& ap_q.idx == CPFS_IDX_STATUS;
	assign wr_ctl = ap_q.sel && ap_q.write && ap_q.idx == CPFS_IDX_CTL;
	assign rd_stat = ap_q.sel && !ap_q.write
		&& ap_q.idx == CPFS_IDX_STATUS;

	// ------------------------------------------------------------
	// fault detection
	// ------------------------------------------------------------
	// qualified detect
	assign det = flten_q ? (fault_in & fin_en_q) : '0;
	assign fault_any = |det;
	assign agg_flag = |ff_q;

	// ------------------------------------------------------------
	// polarity register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			polarity_q <= NCH'(CPFS_POLARITY_RST);
		else if (wr_polar && wp_off_q)
			polarity_q <= wb[NCH-1:0];
	end

	// ------------------------------------------------------------
	// control: write protect, fault enable, input enables
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_off_q <= 1'b0;
			flten_q <= 1'b0;
			fin_en_q <= CPFS_FIN_EN_RST[CPFS_NUM_FIN-1:0];
		end
		else if (wr_stat && wb[CPFS_STAT_WPROT])
			wp_off_q <= 1'b0;
		else if (wr_ctl)
		begin
			if (wb[CPFS_CTL_WPOFF] && wp_armed_q)
				wp_off_q <= 1'b1;
			flten_q <= wb[CPFS_CTL_FLTEN];
			fin_en_q <= wb[CPFS_CTL_FIN_LSB +: CPFS_NUM_FIN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wp_armed_q <= 1'b0;
		else if (rd_stat)
			wp_armed_q <= !wp_off_q;
		else if (wr_ctl)
			wp_armed_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// per-input flags and clear sequence
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CPFS_NUM_FIN; gi++)
		begin : g_fin
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					ff_q[gi] <= 1'b0;
					armed_q[gi] <= 1'b0;
				end
				else
				begin
					if (det[gi])
					begin
						ff_q[gi] <= 1'b1;
						armed_q[gi] <= 1'b0;
					end
					else if (wr_stat && !wb[CPFS_STAT_AGG]
						&& armed_q[gi] && !fault_any)
					begin
						ff_q[gi] <= 1'b0;
						armed_q[gi] <= 1'b0;
					end
					else if (wr_stat && !wb[gi] && armed_q[gi])
					begin
						ff_q[gi] <= 1'b0;
						armed_q[gi] <= 1'b0;
					end
					else if (rd_stat)
						armed_q[gi] <= ff_q[gi];
					else if (wr_stat)
						armed_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read data and response
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (hready && hsel && !hwrite
			&& htrans == CPFS_HTRANS_NONSEQ
			&& hsize == CPFS_HSIZE_WORD)
		begin
			hrdata <= '0;
			unique case (haddr[17:2])
				CPFS_IDX_POLARITY: hrdata[NCH-1:0] <= polarity_q;
				CPFS_IDX_STATUS:
				begin
					hrdata[CPFS_STAT_AGG] <= agg_flag;
					hrdata[CPFS_STAT_WPROT] <= !wp_off_q;
					hrdata[CPFS_STAT_FLTIN] <= fault_any;
					hrdata[CPFS_NUM_FIN-1:0] <= ff_q;
				end
				CPFS_IDX_CTL:
				begin
					hrdata[CPFS_CTL_WPOFF] <= wp_off_q;
					hrdata[CPFS_CTL_FLTEN] <= flten_q;
					hrdata[CPFS_CTL_FIN_LSB +: CPFS_NUM_FIN] <= fin_en_q;
				end
				default: hrdata <= '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ch_out <= '0;
		else if (fault_any || (flten_q && agg_flag))
			ch_out <= polarity_q;
		else
			ch_out <= ch_wave ^ polarity_q;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_polar_prot;
		@(posedge hclk) disable iff (!hresetn)
		(wr_polar && !wp_off_q) |=> $stable(polarity_q);
	endproperty
	a_polar_prot: assert property (p_polar_prot)
		else $error("polarity changed while protected");

	property p_safe;
		@(posedge hclk) disable iff (!hresetn)
		fault_any |=> ch_out == $past(polarity_q);
	endproperty
	a_safe: assert property (p_safe)
		else $error("safe level not driven");

	property p_inv;
		@(posedge hclk) disable iff (!hresetn)
		(!fault_any && !(flten_q && agg_flag))
		|=> ch_out == ($past(ch_wave) ^ $past(polarity_q));
	endproperty
	a_inv: assert property (p_inv)
		else $error("polarity inversion wrong");

	property p_agg;
		@(posedge hclk) disable iff (!hresetn)
		(|det) |=> agg_flag;
	endproperty
	a_agg: assert property (p_agg)
		else $error("aggregate flag not set");

	property p_w1;
		@(posedge hclk) disable iff (!hresetn)
		(wr_stat && wb[CPFS_STAT_AGG]
			&& wb[CPFS_NUM_FIN-1:0] == ff_q)
		|=> agg_flag == $past(agg_flag) || $past(fault_any);
	endproperty
	a_w1: assert property (p_w1)
		else $error("write of one changed flag");

	property p_newf;
		@(posedge hclk) disable iff (!hresetn)
		(wr_stat && fault_any) |=> agg_flag;
	endproperty
	a_newf: assert property (p_newf)
		else $error("clear not abandoned");

	property p_noclr;
		@(posedge hclk) disable iff (!hresetn)
		(agg_flag && !wr_stat) |=> agg_flag;
	endproperty
	a_noclr: assert property (p_noclr)
		else $error("flag cleared without write");

	property p_wp;
		@(posedge hclk) disable iff (!hresetn)
		(wr_stat && wb[CPFS_STAT_WPROT]) |=> !wp_off_q;
	endproperty
	a_wp: assert property (p_wp)
		else $error("write protect not set");

	property p_set;
		@(posedge hclk) disable iff (!hresetn)
		!flten_q |=> ff_q == $past(ff_q) || (ff_q & ~$past(ff_q)) == '0;
	endproperty
	a_set: assert property (p_set)
		else $error("flag set without fault control");
endmodule

//--- tb/test_cpfs_top.sv
`timescale 1ns/1ps
module test_cpfs_top;
	import cpfs_pkg::*;
	// ------------------------------------------------------------
	// bench state
	// ------------------------------------------------------------
	localparam logic [31:0] A_POLAR = {14'h0000, CPFS_IDX_POLARITY, 2'h0};
	localparam logic [31:0] A_STAT = {14'h0000, CPFS_IDX_STATUS, 2'h0};
	localparam logic [31:0] A_CTL = {14'h0000, CPFS_IDX_CTL, 2'h0};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] ch_wave = 8'h00;
	logic [3:0] fault_in = 4'h0;
	wire logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [7:0] ch_out;
	logic [31:0] rd;
	int fail_count = 0;
	int compares = 0;
	// wave in the upper byte, expected pins with polarity A5 below
	logic [15:0] rows [4] = '{16'h00A5, 16'hFF5A, 16'h0FAA, 16'hF055};
	always #10 hclk = ~hclk;
	assign hready = hreadyout;
	cpfs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ch_wave(ch_wave),
		.fault_in(fault_in), .ch_out(ch_out));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task finish_test;
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= CPFS_HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= CPFS_HSIZE_WORD;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input string n, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		cyc(8);
		hresetn <= 1'b1;
		rchk("polarity", A_POLAR, 32'h0);
		rchk("status", A_STAT, 32'h40);
		bus(1'b1, A_POLAR, 32'hFF);
		rchk("polarity", A_POLAR, 32'h0);
		bus(1'b1, A_CTL, 32'hF3);
		rchk("status", A_STAT, 32'h0);
		bus(1'b1, A_POLAR, 32'hA5);
		rchk("polarity", A_POLAR, 32'hA5);
		foreach (rows[i])
		begin
			ch_wave <= rows[i][15:8];
			cyc(3);
			chk("ch_out", {24'h0, rows[i][7:0]}, {24'h0, ch_out});
		end
		fault_in <= 4'h1;
		cyc(3);
		chk("ch_out", 32'hA5, {24'h0, ch_out});
		rchk("status", A_STAT, 32'hA1);
		bus(1'b1, A_STAT, 32'h0);
		rchk("status", A_STAT, 32'hA1);
		fault_in <= 4'h0;
		cyc(2);
		rchk("status", A_STAT, 32'h81);
		bus(1'b1, A_STAT, 32'h81);
		rchk("status", A_STAT, 32'h81);
		fault_in <= 4'h1;
		cyc(2);
		fault_in <= 4'h0;
		cyc(2);
		bus(1'b1, A_STAT, 32'h0);
		rchk("status", A_STAT, 32'h81);
		bus(1'b1, A_STAT, 32'h0);
		rchk("status", A_STAT, 32'h0);
		chk("ch_out", 32'h55, {24'h0, ch_out});
		fault_in <= 4'h3;
		cyc(2);
		fault_in <= 4'h0;
		cyc(2);
		rchk("status", A_STAT, 32'h83);
		bus(1'b1, A_STAT, 32'h82);
		rchk("status", A_STAT, 32'h82);
		bus(1'b1, A_STAT, 32'h80);
		rchk("status", A_STAT, 32'h0);
		bus(1'b1, A_CTL, 32'hB3);
		fault_in <= 4'h4;
		cyc(3);
		rchk("status", A_STAT, 32'h0);
		chk("ch_out", 32'h55, {24'h0, ch_out});
		fault_in <= 4'h0;
		bus(1'b1, A_STAT, 32'h40);
		rchk("status", A_STAT, 32'h40);
		bus(1'b1, A_POLAR, 32'h0);
		rchk("polarity", A_POLAR, 32'hA5);
		bus(1'b1, A_CTL, 32'hF0);
		rchk("control", A_CTL, 32'hF0);
		fault_in <= 4'h1;
		cyc(3);
		rchk("status", A_STAT, 32'h40);
		chk("ch_out", 32'h55, {24'h0, ch_out});
		fault_in <= 4'h0;
		rchk("unmapped", 32'h0000C3A0, 32'h0);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		rchk("polarity", A_POLAR, 32'h0);
		rchk("status", A_STAT, 32'h40);
		finish_test;
	end
	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial
	begin
		#100us;
		fail_count++;
		finish_test;
	end
endmodule
